// ===== timer16_cfg.svh
/*
  Constants of the 16-bit timer waveform block: register offsets, field
  positions, reset values, fixed TOP values and mode numbers.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_A   12'h000
`define OFS_CONTROL_B   12'h004
`define OFS_COMPARE_A   12'h008
`define OFS_COMPARE_B   12'h00C
`define OFS_CAPTURE     12'h010
`define OFS_COUNTER     12'h014
`define OFS_STATUS      12'h018
`define OFS_MASK        12'h01C
`define OFS_PORT        12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CA_MODE_A_HI    7
`define CA_MODE_A_LO    6
`define CA_MODE_B_HI    5
`define CA_MODE_B_LO    4
`define CA_WAVE_HI      1
`define CA_WAVE_LO      0
`define CA_IMPL_MASK    8'hF3
`define CB_WAVE_HI      4
`define CB_WAVE_LO      3
`define CB_RUN          0
`define CB_IMPL_MASK    8'h19
`define ST_OVERFLOW     0
`define ST_MATCH_A      1
`define ST_MATCH_B      2
`define ST_WIDTH        3
`define PT_DIR_A        0
`define PT_DIR_B        1
`define PT_DATA_A       2
`define PT_DATA_B       3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

// ----------------------------------------------------------------
// Counter limits
// ----------------------------------------------------------------
`define CNT_BOTTOM      16'h0000
`define CNT_MAX         16'hFFFF
`define TOP_8BIT        16'h00FF
`define TOP_9BIT        16'h01FF
`define TOP_10BIT       16'h03FF

// ----------------------------------------------------------------
// Waveform mode numbers
// ----------------------------------------------------------------
`define WM_NORMAL       4'h0
`define WM_PC8          4'h1
`define WM_PC9          4'h2
`define WM_PC10         4'h3
`define WM_CTC_OCR      4'h4
`define WM_FAST8        4'h5
`define WM_FAST9        4'h6
`define WM_FAST10       4'h7
`define WM_PFC_ICR      4'h8
`define WM_PFC_OCR      4'h9
`define WM_PC_ICR       4'hA
`define WM_PC_OCR       4'hB
`define WM_CTC_ICR      4'hC
`define WM_RESERVED     4'hD
`define WM_FAST_ICR     4'hE
`define WM_FAST_OCR     4'hF

`endif

// ===== timer16_pkg.sv
/*
  Types shared by the timer waveform block.
  Assumes nothing of its surroundings.
*/
package timer16_pkg;

  // Waveform family picked by the 4-bit mode
  typedef enum logic [1:0] {
    CLASS_PLAIN = 2'h0,
    CLASS_FAST  = 2'h1,
    CLASS_DUAL  = 2'h3
  } wave_class_e;

  // Count direction of the dual-slope sequence
  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_e;

endpackage

// ===== compare_out_unit.sv
/*
  One compare output channel: holds the compare output level and
  decides, from the family and the output mode field, how it reacts to
  a match and to TOP.
  Assumes match and TOP strobes are one-cycle pulses on pclk and tick is a clock enable.
*/
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module compare_out_unit
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Mode
  input  wire wave_class_e wave_class,
  input  wire logic        toggle_allowed,
  input  wire logic [1:0]  out_mode,
  // Counter events
  input  wire logic        tick,
  input  wire logic        match,
  input  wire logic        at_top,
  input  wire logic        ocr_is_top,
  input  wire count_dir_e  dir,
  // Result
  output logic             level
);

  logic level_next;

  always_comb
  begin
    level_next = level;
    case (wave_class)
      CLASS_PLAIN:
      begin
        if (match)
        begin
          case (out_mode)
            2'h1:    level_next = ~level;
            2'h2:    level_next = 1'b0;
            2'h3:    level_next = 1'b1;
            default: level_next = level;
          endcase
        end
      end
      CLASS_FAST:
      begin
        if (out_mode == 2'h1)
        begin
          if (match && toggle_allowed)
            level_next = ~level;
        end
        else if (out_mode[1])
        begin
          // Match equal to TOP is dropped so only the TOP action shows
          if (at_top)
            level_next = ~out_mode[0];
          else if (match && !ocr_is_top)
            level_next = out_mode[0];
        end
      end
      CLASS_DUAL:
      begin
        if (match)
        begin
          if (out_mode == 2'h1)
          begin
            if (toggle_allowed)
              level_next = ~level;
          end
          else if (out_mode[1])
          begin
            if (dir == DIR_UP)
              level_next = out_mode[0];
            else
              level_next = ~out_mode[0];
          end
        end
      end
      default: level_next = level;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level <= 1'b0;
    else if (tick)
      level <= level_next;
  end

endmodule

// ===== timer16_waveform.sv
/*
  16-bit timer waveform block: APB register file, waveform mode decode,
  counter with single and dual slope sequences, double-buffered compare
  registers, two compare output channels driving port pins, overflow and
  match flags with a masked level interrupt.
  Assumes an APB master on pclk and output-only port pins whose enable is
  active low.
*/
// Chosen here: the APB slave port and the register offsets.
// Operation
// - Nonzero A mode field routes A to pin; here 01 routes A only where A may toggle
// - Nonzero B mode field routes B to pin; here 01 routes B only in plain modes
// - Pin driven only when direction bit set
// - Output field meaning depends on waveform family
// - Plain modes: off, toggle, clear, set
// - Fast 01 toggles A only in 14, 15
// - Fast: 10 clear-match/set-top, 11 inverse
// - Fast: match at TOP ignored, TOP acts
// - Dual 01 toggles A only in 8-11
// - Dual 10 clears up, sets down; 11 inverse
// - Mode is low two plus high two bits
// - Mode 0 normal, TOP 0xFFFF, flag MAX
// - Modes 4, 12 clear on match; 13 reserved
// - Modes 1-3, 10, 11 phase correct PWM
// - Modes 8, 9 update and flag at BOTTOM
// - Dual slope: up, hold TOP, down; here TOP lasts one tick like any count
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module timer16_waveform
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Compare output pins
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  timer16_control_a_reg;
  logic [7:0]  timer16_control_b_reg;
  logic [15:0] compare_buf_a_reg;
  logic [15:0] compare_buf_b_reg;
  logic [15:0] compare_reg_a;
  logic [15:0] compare_reg_b;
  logic [15:0] capture_reg;
  logic [15:0] count_reg;
  count_dir_e  dir_reg;
  logic [`ST_WIDTH-1:0] status_reg;
  logic [`ST_WIDTH-1:0] mask_reg;
  logic [3:0]  port_reg;

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;

  // One wait state so that pready and prdata both leave flip-flops
  assign access = psel && penable && !pready;
  assign wr_en  = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CONTROL_A: rd_mux = {24'h000000, timer16_control_a_reg};
      `OFS_CONTROL_B: rd_mux = {24'h000000, timer16_control_b_reg};
      `OFS_COMPARE_A: rd_mux = {16'h0000, compare_buf_a_reg};
      `OFS_COMPARE_B: rd_mux = {16'h0000, compare_buf_b_reg};
      `OFS_CAPTURE:   rd_mux = {16'h0000, capture_reg};
      `OFS_COUNTER:   rd_mux = {16'h0000, count_reg};
      `OFS_STATUS:    rd_mux = {29'h00000000, status_reg};
      `OFS_MASK:      rd_mux = {29'h00000000, mask_reg};
      `OFS_PORT:      rd_mux = {28'h0000000, port_reg};
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer16_control_a_reg <= `RST_BYTE;
      timer16_control_b_reg <= `RST_BYTE;
      capture_reg           <= `RST_WORD;
      mask_reg              <= '0;
      port_reg              <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_CONTROL_A:
          timer16_control_a_reg <= pwdata[7:0] & `CA_IMPL_MASK;
        `OFS_CONTROL_B:
          timer16_control_b_reg <= pwdata[7:0] & `CB_IMPL_MASK;
        `OFS_CAPTURE: capture_reg <= pwdata[15:0];
        `OFS_MASK:    mask_reg    <= pwdata[`ST_WIDTH-1:0];
        `OFS_PORT:    port_reg    <= pwdata[3:0];
        default:      port_reg    <= port_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [3:0]  waveform_mode;
  wave_class_e wave_class;
  logic [15:0] top_value;
  logic        update_at_top;
  logic        update_at_bottom;

  assign waveform_mode =
    {timer16_control_b_reg[`CB_WAVE_HI:`CB_WAVE_LO],
     timer16_control_a_reg[`CA_WAVE_HI:`CA_WAVE_LO]};

  always_comb
  begin
    wave_class       = CLASS_PLAIN;
    top_value        = `CNT_MAX;
    update_at_top    = 1'b0;
    update_at_bottom = 1'b0;
    case (waveform_mode)
      `WM_NORMAL:   top_value = `CNT_MAX;
      `WM_CTC_OCR:  top_value = compare_reg_a;
      `WM_CTC_ICR:  top_value = capture_reg;
      `WM_RESERVED: top_value = `CNT_MAX;
      `WM_PC8, `WM_PC9, `WM_PC10:
      begin
        wave_class    = CLASS_DUAL;
        update_at_top = 1'b1;
        top_value     = (waveform_mode == `WM_PC8) ? `TOP_8BIT :
                        (waveform_mode == `WM_PC9) ? `TOP_9BIT :
                        `TOP_10BIT;
      end
      `WM_PC_ICR, `WM_PC_OCR:
      begin
        wave_class    = CLASS_DUAL;
        update_at_top = 1'b1;
        top_value     = waveform_mode[0] ? compare_reg_a : capture_reg;
      end
      `WM_PFC_ICR, `WM_PFC_OCR:
      begin
        wave_class       = CLASS_DUAL;
        update_at_bottom = 1'b1;
        top_value        = waveform_mode[0] ? compare_reg_a : capture_reg;
      end
      `WM_FAST8, `WM_FAST9, `WM_FAST10:
      begin
        wave_class    = CLASS_FAST;
        update_at_top = 1'b1;
        top_value     = (waveform_mode == `WM_FAST8) ? `TOP_8BIT :
                        (waveform_mode == `WM_FAST9) ? `TOP_9BIT :
                        `TOP_10BIT;
      end
      `WM_FAST_ICR, `WM_FAST_OCR:
      begin
        wave_class    = CLASS_FAST;
        update_at_top = 1'b1;
        top_value     = waveform_mode[0] ? compare_reg_a : capture_reg;
      end
      default: top_value = `CNT_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic tick;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic match_a;
  logic match_b;

  // Timer clock enable; undivided here, so a tick is every running cycle
  assign tick      = timer16_control_b_reg[`CB_RUN];
  assign at_top    = tick && (count_reg == top_value);
  assign at_bottom = tick && (count_reg == `CNT_BOTTOM);
  assign at_max    = tick && (count_reg == `CNT_MAX);
  assign match_a   = tick && (count_reg == compare_reg_a);
  assign match_b   = tick && (count_reg == compare_reg_b);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= `CNT_BOTTOM;
      dir_reg   <= DIR_UP;
    end
    else if (wr_en && paddr == `OFS_COUNTER)
      count_reg <= pwdata[15:0];
    else if (tick)
    begin
      case (wave_class)
        CLASS_DUAL:
        begin
          // TOP and BOTTOM each last one tick before the turn
          if (dir_reg == DIR_UP && count_reg >= top_value)
          begin
            dir_reg   <= DIR_DOWN;
            count_reg <= count_reg - 16'h0001;
          end
          else if (dir_reg == DIR_DOWN && count_reg == `CNT_BOTTOM)
          begin
            dir_reg   <= DIR_UP;
            count_reg <= count_reg + 16'h0001;
          end
          else if (dir_reg == DIR_UP)
            count_reg <= count_reg + 16'h0001;
          else
            count_reg <= count_reg - 16'h0001;
        end
        default:
        begin
          dir_reg <= DIR_UP;
          if (count_reg == top_value)
            count_reg <= `CNT_BOTTOM;
          else
            count_reg <= count_reg + 16'h0001;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Compare registers, double buffered in PWM families
  // ----------------------------------------------------------------
  logic load_now;

  assign load_now = (update_at_top && at_top) ||
                    (update_at_bottom && at_bottom) ||
                    (!update_at_top && !update_at_bottom);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_buf_a_reg <= `RST_WORD;
      compare_buf_b_reg <= `RST_WORD;
    end
    else if (wr_en && paddr == `OFS_COMPARE_A)
      compare_buf_a_reg <= pwdata[15:0];
    else if (wr_en && paddr == `OFS_COMPARE_B)
      compare_buf_b_reg <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_reg_a <= `RST_WORD;
      compare_reg_b <= `RST_WORD;
    end
    else if (load_now)
    begin
      compare_reg_a <= compare_buf_a_reg;
      compare_reg_b <= compare_buf_b_reg;
    end
  end

  // ----------------------------------------------------------------
  // Compare output channels
  // ----------------------------------------------------------------
  logic level_a;
  logic level_b;
  logic toggle_a_ok;

  // Only channel A may toggle in PWM families, and only with a
  // register-defined TOP
  assign toggle_a_ok =
    (wave_class == CLASS_PLAIN) ||
    (waveform_mode == `WM_FAST_ICR) || (waveform_mode == `WM_FAST_OCR) ||
    (waveform_mode >= `WM_PFC_ICR && waveform_mode <= `WM_PC_OCR);

  compare_out_unit chan_a_unit (
    .pclk           (pclk),
    .presetn        (presetn),
    .wave_class     (wave_class),
    .toggle_allowed (toggle_a_ok),
    .out_mode       (timer16_control_a_reg[`CA_MODE_A_HI:`CA_MODE_A_LO]),
    .tick           (tick),
    .match          (match_a),
    .at_top         (at_top),
    .ocr_is_top     (compare_reg_a == top_value),
    .dir            (dir_reg),
    .level          (level_a)
  );

  compare_out_unit chan_b_unit (
    .pclk           (pclk),
    .presetn        (presetn),
    .wave_class     (wave_class),
    .toggle_allowed (wave_class == CLASS_PLAIN),
    .out_mode       (timer16_control_a_reg[`CA_MODE_B_HI:`CA_MODE_B_LO]),
    .tick           (tick),
    .match          (match_b),
    .at_top         (at_top),
    .ocr_is_top     (compare_reg_b == top_value),
    .dir            (dir_reg),
    .level          (level_b)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic conn_a;
  logic conn_b;

  // A 01 field that cannot toggle here leaves the port in charge
  assign conn_a = timer16_control_a_reg[`CA_MODE_A_HI] ||
                  (timer16_control_a_reg[`CA_MODE_A_LO] && toggle_a_ok);
  assign conn_b = timer16_control_a_reg[`CA_MODE_B_HI] ||
                  (timer16_control_a_reg[`CA_MODE_B_LO] &&
                   wave_class == CLASS_PLAIN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_a_out  <= 1'b0;
      pin_b_out  <= 1'b0;
      pin_a_oe_n <= 1'b1;
      pin_b_oe_n <= 1'b1;
    end
    else
    begin
      pin_a_out  <= conn_a ? level_a : port_reg[`PT_DATA_A];
      pin_b_out  <= conn_b ? level_b : port_reg[`PT_DATA_B];
      pin_a_oe_n <= !port_reg[`PT_DIR_A];
      pin_b_oe_n <= !port_reg[`PT_DIR_B];
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  logic                 ovf_event;
  logic [`ST_WIDTH-1:0] set_bits;
  logic [`ST_WIDTH-1:0] clr_bits;

  always_comb
  begin
    case (wave_class)
      CLASS_FAST: ovf_event = at_top;
      CLASS_DUAL: ovf_event = at_bottom && dir_reg == DIR_DOWN;
      default:    ovf_event = at_max;
    endcase
  end

  assign set_bits = {match_b, match_a, ovf_event};
  assign clr_bits = (wr_en && paddr == `OFS_STATUS) ?
                    pwdata[`ST_WIDTH-1:0] : '0;

  // A flag raised in the cycle of its clear survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~clr_bits) | set_bits;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(((status_reg & ~clr_bits) | set_bits) & mask_reg);
  end

endmodule

// ===== timer16_waveform_asserts.sv
/*
  Checker for the timer waveform block, bound to its top ports.
  Assumes the block's byte offsets and its one-wait-state APB slave.
*/
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module timer16_waveform_asserts
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and interrupt
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe_n,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe_n,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  assign acc = psel && penable && pready;

  AST_READY_WAITED:
    assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a waited access");
  AST_READY_PULSE:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED_ERR:
    assert property (acc && paddr > `OFS_PORT |-> pslverr)
    else $error("unmapped access without error");
  AST_UNMAPPED_ZERO:
    assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_RSVD:
    assert property (acc && !pwrite && paddr == `OFS_CONTROL_A |->
                     prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0)
    else $error("control a unused bits not zero");
  AST_OE_DIR:
    assert property (acc && pwrite && paddr == `OFS_PORT |-> ##2
                     pin_a_oe_n == !$past(pwdata[0], 2) &&
                     pin_b_oe_n == !$past(pwdata[1], 2))
    else $error("pin enable not following direction");
  AST_IRQ_MASKED:
    assert property (acc && pwrite && paddr == `OFS_MASK &&
                     pwdata[2:0] == 3'h0 |-> ##2 !irq [*3])
    else $error("irq high with all masked");
  AST_RESET_QUIET:
    assert property ($rose(presetn) |-> pin_a_oe_n && pin_b_oe_n && !irq)
    else $error("pins or irq active after reset");

  COV_WRITE: cover property (acc && pwrite);
  COV_ERROR: cover property (acc && pslverr);
  COV_IRQ:   cover property ($rose(irq));
endmodule

bind timer16_waveform timer16_waveform_asserts u_asserts (.*);

// ===== pin_load_model.sv
/*
  Load on one compare output pad.
  Assumes an active-low output enable; an undriven pad flips every
  cycle so a stale level is never mistaken for a driven one.
*/
`timescale 1ns/1ns

module pin_load_model
(
  // Clock
  input  wire logic pclk,
  // Pin from the block
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Pad level
  output logic      pad
);
  logic held_reg = 1'b0;

  always @(posedge pclk)
    held_reg <= pad;

  assign pad = pin_oe_n ? ~held_reg : pin_out;
endmodule

// ===== tb_top.sv
/*
  Self-checking bench: registers over APB, compare output modes on pads.
  Assumes the block's byte offsets and a 25 MHz pclk.
*/
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rv;
  logic        pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, irq;
  logic        pad_a, pad_b, ev, lvl;
  int          n_errors, cmp_count, i;

  timer16_waveform dut (.*);
  pin_load_model load_a (.pclk, .pin_out(pin_a_out),
                         .pin_oe_n(pin_a_oe_n), .pad(pad_a));
  pin_load_model load_b (.pclk, .pin_out(pin_b_out),
                         .pin_oe_n(pin_b_oe_n), .pad(pad_b));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic np_exp(input logic [1:0] m, input logic p);
    return (m == 2'h1) ? ~p : m[0];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    chk("pready", 1, pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  // Mode is changed with the timer stopped, so no half-set mode runs
  task automatic setm(input logic [3:0] m, input logic [3:0] ch);
    wr(`OFS_CONTROL_B, 32'h0);
    wr(`OFS_CONTROL_A, {24'h0, ch, 2'b00, m[1:0]});
    wr(`OFS_CONTROL_B, {27'h0, m[3:2], 3'b000});
  endtask
  task automatic go(input logic [3:0] m, input logic [15:0] c);
    wr(`OFS_COUNTER, {16'h0, c});
    wr(`OFS_CONTROL_B, {27'h0, m[3:2], 3'b001});
  endtask
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole sequence needs about 1300 cycles
  initial
  begin
    repeat (4000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h262540DE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 9; i++)
      rd(12'(i * 4), 32'h0, "reset value");
    wr(12'h024, 32'hFFFFFFFF);
    chk("write error", 1, ev);
    rd(12'h040, 32'h0, "unmapped read");
    chk("read error", 1, ev);
    for (i = 0; i < 4; i++)
    begin
      seed = xorshift(seed);
      wr(`OFS_CONTROL_A, seed | 32'hC);
      rd(`OFS_CONTROL_A, seed & 32'hF3, "control a");
    end
    setm(4'h0, 4'h0);
    wr(`OFS_PORT, 32'hC);
    chk("oe a", 1, pin_a_oe_n);
    wr(`OFS_PORT, 32'hF);
    // Pin flops follow the port write one cycle late
    repeat (2) @(posedge pclk);
    chk("pad a", 1, pad_a);
    chk("pad b", 1, pad_b);
    chk("oe a", 0, pin_a_oe_n);
    chk("oe b", 0, pin_b_oe_n);
    setm(4'h0, 4'h7);
    chk("pad a", 0, pad_a);
    chk("pad b", 0, pad_b);
    wr(`OFS_COMPARE_A, 32'h4);
    wr(`OFS_COMPARE_B, 32'h4);
    lvl = 1'b0;
    for (i = 1; i < 4; i++)
    begin
      setm(4'h0, {i[1:0], i[1:0]});
      go(4'h0, 16'h0);
      repeat (10) @(posedge pclk);
      lvl = np_exp(i[1:0], lvl);
      chk("pad a", lvl, pad_a);
      chk("pad b", lvl, pad_b);
    end
    wr(`OFS_STATUS, 32'h7);
    wr(`OFS_MASK, 32'h1);
    go(4'h0, 16'hFFF0);
    repeat (25) @(posedge pclk);
    setm(4'h0, 4'h0);
    chk("irq", 1, irq);
    rd(`OFS_STATUS, 32'h7, "status");
    wr(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS, 32'h6, "status");
    chk("irq", 0, irq);
    wr(`OFS_MASK, 32'h0);
    setm(4'h0, 4'hA);
    wr(`OFS_COMPARE_A, 32'h10);
    wr(`OFS_COMPARE_B, 32'hFF);
    setm(4'h5, 4'hA);
    go(4'h5, 16'h20);
    repeat (248) @(posedge pclk);
    chk("pad a", 0, pad_a);
    chk("pad b", 1, pad_b);
    repeat (240) @(posedge pclk);
    chk("pad a", 1, pad_a);
    chk("pad b", 1, pad_b);
    setm(4'h0, 4'hB);
    wr(`OFS_COMPARE_A, 32'h80);
    wr(`OFS_COMPARE_B, 32'h80);
    setm(4'h1, 4'hB);
    go(4'h1, 16'h70);
    repeat (40) @(posedge pclk);
    chk("pad a", 0, pad_a);
    chk("pad b", 1, pad_b);
    repeat (250) @(posedge pclk);
    chk("pad a", 1, pad_a);
    chk("pad b", 0, pad_b);
    // Port data opposite to the held levels, so a stray route shows
    wr(`OFS_PORT, 32'hB);
    setm(4'h1, 4'h5);
    go(4'h1, 16'h70);
    repeat (100) @(posedge pclk);
    chk("pad a", 0, pad_a);
    chk("pad b", 1, pad_b);
    close_out();
  end
endmodule
